// [dv/fifo_write_port_sdr_ddr_tb.sv]
`timescale 1ns/100ps
module fifo_write_port_sdr_ddr_tb;
   logic clk;
   logic nrst;
   logic dual;
   logic done;
   logic [3:0] rd_req, wclk, wen_n, wsel_n, full, afull, rd_valid, empty;
   fwp_pkg::fwp_data_arr_t wdata, rd_data;
   fwp_pkg::fwp_setup_t setup, latched, s;
   int fails = 0;
   int compares = 0;

   // 250 MHz system clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   fwp_writer i_wr (.dual(dual), .wclk(wclk), .wen_n(wen_n), .write_select_n(wsel_n), .wdata(wdata));
   fwp_top #(.SETTLE_CYC(2)) i_dut (.CLK(clk), .NRST(nrst), .WCLK(wclk), .WEN_N(wen_n),
      .WRITE_SELECT_N(wsel_n), .WDATA(wdata), .SETUP(setup), .RD_REQ(rd_req),
      .FULL_OR_INPUT_READY(full), .ALMOST_FULL_FLAG(afull), .RD_DATA(rd_data), .RD_VALID(rd_valid),
      .FIFO_EMPTY(empty), .SETUP_LATCHED(latched), .SETUP_DONE(done));

   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
      begin
         $display("bench passed");
      end
      else
      begin
         $display("bench failed");
      end
      $finish;
   endtask

   // set-up changes only while reset is held
   task automatic rst(input fwp_pkg::fwp_setup_t v);
      int w;
      @(posedge clk);
      nrst <= 1'b0;
      @(posedge clk);
      setup <= v;
      dual <= ~v.quad_dual_select;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      w = 0;
      while (done !== 1'b1 && w < 40)
      begin
         @(posedge clk);
         #1;
         w++;
      end
      chk(10'(done), 10'h001);
      chk(latched, v);
      // enables still cross into the write domains
      repeat (10) @(posedge clk);
   endtask

   // n words expected as base, base+step, ...
   task automatic drain(input int p, input int n, input logic [9:0] base, input logic [9:0] step);
      int w;
      for (int k = 0; k < n; k++)
      begin
         w = 0;
         while (empty[p] !== 1'b0 && w < 40)
         begin
            @(posedge clk);
            #1;
            w++;
         end
         chk(10'(empty[p]), 10'h000);
         @(posedge clk);
         rd_req[p] <= 1'b1;
         @(posedge clk);
         rd_req[p] <= 1'b0;
         #1;
         chk(10'(rd_valid[p]), 10'h001);
         chk(rd_data[p], base + 10'(k) * step);
      end
   endtask

   // hang guard, many times the expected run
   initial
   begin
      #100000;
      fails++;
      finish_test();
   end

   ////////////////////////////////////////////////////////////
   initial
   begin
      nrst = 1'b0;
      rd_req = 4'h0;
      dual = 1'b0;
      s = '0;
      s.quad_dual_select = 1'b1;
      setup = s;
      rst(s);
      // single rate, second burst with chip select off
      i_wr.put(0, 3, 10'h010, 1'b0);
      i_wr.put(0, 2, 10'h020, 1'b1);
      drain(0, 3, 10'h010, 10'h002);
      repeat (20) @(posedge clk);
      #1 chk(10'(empty[0]), 10'h001);
      $display("test single rate done");
      // independent quad ports at once
      fork
         i_wr.put(1, 2, 10'h080, 1'b0);
         i_wr.put(2, 2, 10'h0c0, 1'b0);
      join
      drain(1, 2, 10'h080, 10'h002);
      drain(2, 2, 10'h0c0, 10'h002);
      $display("test quad done");
      // overfill: two extra words dropped
      i_wr.put(3, 18, 10'h040, 1'b0);
      #1 chk(10'(full[3]), 10'h000);
      chk(10'(afull[3]), 10'h000);
      drain(3, 16, 10'h040, 10'h002);
      repeat (20) @(posedge clk);
      #1 chk(10'(empty[3]), 10'h001);
      chk(10'(full[3]), 10'h001);
      $display("test full done");
      // double rate, dual, input-ready meaning, offset 8
      s.write_rate_select = 1'b1;
      s.quad_dual_select = 1'b0;
      s.fallthrough_or_serial_in = 1'b1;
      s.default_offset_select = 2'h3;
      rst(s);
      fork
         i_wr.put(0, 2, 10'h200, 1'b0);
         i_wr.put(2, 5, 10'h300, 1'b0);
      join
      #1 chk(10'(full[0]), 10'h000);
      chk(10'(afull[0]), 10'h001);
      chk(10'(afull[2]), 10'h000);
      chk(10'(full[1]), 10'h001);
      drain(0, 4, 10'h200, 10'h001);
      drain(2, 10, 10'h300, 10'h001);
      $display("test double rate done");
      // quad again, offset 4: almost full exactly at four free words
      s.write_rate_select = 1'b0;
      s.quad_dual_select = 1'b1;
      s.fallthrough_or_serial_in = 1'b0;
      s.default_offset_select = 2'h2;
      rst(s);
      i_wr.put(1, 11, 10'h100, 1'b0);
      #1 chk(10'(afull[1]), 10'h001);
      i_wr.put(1, 1, 10'h120, 1'b0);
      #1 chk(10'(afull[1]), 10'h000);
      chk(10'(full[1]), 10'h001);
      drain(1, 11, 10'h100, 10'h002);
      drain(1, 1, 10'h120, 10'h002);
      $display("test offset done");
      finish_test();
   end
endmodule

// [dv/fwp_top_checker.sv]
`timescale 1ns/100ps
module fwp_top_checker #(
   parameter int SETTLE_CYC = 4
) (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic [3:0] WCLK,
   input wire fwp_pkg::fwp_setup_t SETUP,
   input wire logic [3:0] RD_REQ,
   input wire logic [3:0] FULL_OR_INPUT_READY,
   input wire logic [3:0] ALMOST_FULL_FLAG,
   input wire logic [3:0] FIFO_EMPTY,
   input wire fwp_pkg::fwp_setup_t SETUP_LATCHED,
   input wire logic SETUP_DONE
);
   // clk edges since reset release, saturates
   logic [7:0] age_reg;
   // dual mode once set-up is done
   logic dual_run;
   assign dual_run = SETUP_DONE && !SETUP_LATCHED.quad_dual_select;
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         age_reg <= 8'h00;
      end
      else if (age_reg != 8'hff)
      begin
         age_reg <= age_reg + 8'h01;
      end
   end
   // set-up finishing step
   sequence done_rise_s;
      !SETUP_DONE ##1 SETUP_DONE;
   endsequence
   ////////////////////////////////////////////////////////////
   done_time_a: assert property (@(posedge CLK) disable iff (!NRST)
      done_rise_s |-> age_reg == 8'(SETTLE_CYC + 3)) else $error("set-up done late");
   done_hold_a: assert property (@(posedge CLK) disable iff (!NRST)
      SETUP_DONE |=> SETUP_DONE) else $error("set-up done dropped");
   latch_match_a: assert property (@(posedge CLK) disable iff (!NRST)
      SETUP_DONE |-> SETUP_LATCHED == SETUP) else $error("latched set-up differs");
   idle_early_a: assert property (@(posedge CLK) disable iff (!NRST)
      !SETUP_DONE |-> (&FULL_OR_INPUT_READY) && (&FIFO_EMPTY)) else $error("port live early");
   keep_words_a: assert property (@(posedge CLK) disable iff (!NRST)
      ##1 (~$past(FIFO_EMPTY) & ~$past(RD_REQ) & FIFO_EMPTY) == 4'h0) else $error("words lost");
   odd_flag_a: assert property (@(posedge CLK) disable iff (!NRST)
      dual_run |-> &{FULL_OR_INPUT_READY[1], FULL_OR_INPUT_READY[3], ALMOST_FULL_FLAG[1], ALMOST_FULL_FLAG[3]})
      else $error("odd flag low");
   odd_empty_a: assert property (@(posedge CLK) disable iff (!NRST)
      dual_run |-> FIFO_EMPTY[1] && FIFO_EMPTY[3]) else $error("odd fifo written");
   full_af_a: assert property (@(posedge WCLK[3]) disable iff (!NRST)
      SETUP_DONE && $past(SETUP_DONE, 4) && (FULL_OR_INPUT_READY[3] == SETUP_LATCHED.fallthrough_or_serial_in)
      |-> !ALMOST_FULL_FLAG[3]) else $error("full without almost full");
endmodule

bind fwp_top fwp_top_checker #(.SETTLE_CYC(SETTLE_CYC)) i_chk (
   .CLK(CLK),
   .NRST(NRST),
   .WCLK(WCLK),
   .SETUP(SETUP),
   .RD_REQ(RD_REQ),
   .FULL_OR_INPUT_READY(FULL_OR_INPUT_READY),
   .ALMOST_FULL_FLAG(ALMOST_FULL_FLAG),
   .FIFO_EMPTY(FIFO_EMPTY),
   .SETUP_LATCHED(SETUP_LATCHED),
   .SETUP_DONE(SETUP_DONE)
);

// [dv/fwp_writer.sv]
`timescale 1ns/100ps
module fwp_writer (
   input wire logic dual,
   output logic [3:0] wclk,
   output logic [3:0] wen_n,
   output logic [3:0] write_select_n,
   output fwp_pkg::fwp_data_arr_t wdata
);
   // free write clock, 6 ns, offset from the system clock
   logic gclk = 1'b0;
   initial
   begin
      #1.3;
      forever #3 gclk = ~gclk;
   end
   // dual mode grounds the unused clocks
   assign wclk = dual ? {1'b0, gclk, 1'b0, gclk} : {4{gclk}};
   // qualifiers idle high; odd ones never leave it in dual mode
   initial
   begin
      wen_n = 4'hf;
      write_select_n = 4'hf;
      wdata = '0;
   end
   ////////////////////////////////////////////////////////////
   // n cycles: rising words base+2k, falling words base+2k+1
   task automatic put(input int p, input int n, input logic [9:0] base, input logic cs_n);
      @(posedge wclk[p]);
      wen_n[p] <= 1'b0;
      write_select_n[p] <= cs_n;
      wdata[p] <= base;
      for (int k = 0; k < n; k++)
      begin
         @(posedge wclk[p]);
         // enable off at the falling edge must not matter
         wen_n[p] <= 1'b1;
         wdata[p] <= base + 10'(2 * k + 1);
         @(negedge wclk[p]);
         wen_n[p] <= (k == n - 1);
         wdata[p] <= base + 10'(2 * k + 2);
      end
      @(posedge wclk[p]);
      write_select_n[p] <= 1'b1;
      wdata[p] <= ~wdata[p];
      // extra edges let the published pointer step on after a double rate burst
      repeat (2) @(posedge wclk[p]);
   endtask
endmodule

// [verilog/fwp_pkg.sv]
package fwp_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // sizes
   localparam int NUM_FIFO = 4; // four write ports in quad mode
   localparam int DATA_W = 10; // write word width
   localparam int ADDR_W = 4; // log2 of fifo depth, kept small here
   localparam int DEPTH = 1 << ADDR_W; // words per fifo
   localparam int PTR_W = ADDR_W + 1; // pointer with wrap bit
   localparam int CNT_W = 8; // settle counter width

   ////////////////////////////////////////////////////////////////////////////////
   // constants
   localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1); // pointer step
   localparam logic [PTR_W-1:0] FULL_CNT = PTR_W'(DEPTH); // words held when full
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1); // settle step
   localparam int CFG_SETTLE_CYC = 4; // clk cycles before set-up pins are latched
   // default almost-full offsets per offset select code
   localparam logic [PTR_W-1:0] PAF_OFS_0 = 5'h01;
   localparam logic [PTR_W-1:0] PAF_OFS_1 = 5'h02;
   localparam logic [PTR_W-1:0] PAF_OFS_2 = 5'h04;
   localparam logic [PTR_W-1:0] PAF_OFS_3 = 5'h08;

   ////////////////////////////////////////////////////////////////////////////////
   // types
   // set-up pins, latched once after master reset
   typedef struct packed {
      logic write_rate_select; // high: double rate writes
      logic read_rate_select; // read side rate, carried only
      logic quad_dual_select; // high: quad, low: dual
      logic output_width_select;
      logic input_width_select;
      logic [1:0] default_offset_select; // picks almost-full offset
      logic io_level_select;
      logic prog_flag_mode;
      logic fallthrough_or_serial_in; // high: fall-through flag meaning
   } fwp_setup_t;

   // settings handed to one write port
   typedef struct packed {
      logic enable; // port in use
      logic ddr; // double rate capture
      logic fallthrough; // input-ready instead of full
      logic [PTR_W-1:0] paf_offset; // almost-full threshold
   } fwp_port_cfg_t;

   typedef logic [NUM_FIFO-1:0][DATA_W-1:0] fwp_data_arr_t;
   typedef logic [DEPTH-1:0][DATA_W-1:0] fwp_mem_t;
   typedef logic [NUM_FIFO-1:0][PTR_W-1:0] fwp_ptr_arr_t;

   // set-up latch sequence
   typedef enum logic [1:0] {
      CFG_WAIT = 2'b00,
      CFG_LATCH = 2'b01,
      CFG_RUN = 2'b10
   } fwp_cfg_state_t;

   ////////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [PTR_W-1:0] fwp_bin2gray(input logic [PTR_W-1:0] b);
      return b ^ (b >> 1);
   endfunction

   function automatic logic [PTR_W-1:0] fwp_gray2bin(input logic [PTR_W-1:0] g);
      logic [PTR_W-1:0] b;
      b = g;
      for (int k = PTR_W - 2; k >= 0; k--)
      begin
         b[k] = b[k+1] ^ g[k];
      end
      return b;
   endfunction

   function automatic logic [PTR_W-1:0] fwp_default_offset(input logic [1:0] sel);
      if (sel == 2'h0)
      begin
         return PAF_OFS_0;
      end
      else if (sel == 2'h1)
      begin
         return PAF_OFS_1;
      end
      else if (sel == 2'h2)
      begin
         return PAF_OFS_2;
      end
      return PAF_OFS_3;
   endfunction

endpackage

// [verilog/fwp_port.sv]
`timescale 1ns/100ps
module fwp_port (
   input wire logic wclk,
   input wire logic nrst,
   input wire fwp_pkg::fwp_port_cfg_t port_cfg,
   input wire logic wen_n,
   input wire logic write_select_n,
   input wire logic [fwp_pkg::DATA_W-1:0] wdata,
   input wire logic [fwp_pkg::PTR_W-1:0] rd_gray,
   output logic [fwp_pkg::PTR_W-1:0] wr_gray,
   output fwp_pkg::fwp_mem_t mem,
   output logic full_or_input_ready,
   output logic almost_full_flag
);

   ////////////////////////////////////////////////////////////////////////////////
   // state of the write clock domain
   typedef struct packed {
      fwp_pkg::fwp_port_cfg_t cfg_s1; // settings, first sync stage
      fwp_pkg::fwp_port_cfg_t cfg_s2; // settings, usable
      logic [fwp_pkg::PTR_W-1:0] rdg_s1; // read pointer, first sync stage
      logic [fwp_pkg::PTR_W-1:0] rdg_s2; // read pointer, usable
      logic [fwp_pkg::PTR_W-1:0] wr_bin; // write pointer
      logic [fwp_pkg::PTR_W-1:0] pub_bin; // published write pointer, binary
      logic [fwp_pkg::PTR_W-1:0] wr_gray; // published write pointer
      logic pend_fall; // falling-edge word owed to the fifo
      fwp_pkg::fwp_mem_t mem; // storage
      logic flag_fr; // full or input ready, active low
      logic flag_paf; // almost full, active low
   } fwp_wr_state_t;

   localparam fwp_wr_state_t WR_RESET = '{flag_fr: 1'b1, flag_paf: 1'b1, default: '0};

   fwp_wr_state_t wr_reg; // registered state
   fwp_wr_state_t wr_next; // next state
   logic [fwp_pkg::DATA_W-1:0] fall_data_reg; // word seen at the falling edge

   ////////////////////////////////////////////////////////////////////////////////
   // falling edge capture; the word is committed at the next rising edge,
   // so a double rate burst needs one more rising edge after its last word
   always_ff @(negedge wclk or negedge nrst)
   begin
      if (!nrst)
      begin
         fall_data_reg <= '0;
      end
      else
      begin
         fall_data_reg <= wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // write pointer, storage and flags
   always_comb
   begin
      fwp_pkg::fwp_port_cfg_t cfg;
      logic [fwp_pkg::PTR_W-1:0] rd_bin;
      logic [fwp_pkg::PTR_W-1:0] ptr;
      logic [fwp_pkg::PTR_W-1:0] used;
      logic [fwp_pkg::PTR_W-1:0] free;
      logic accept_rise;
      cfg = wr_reg.cfg_s2;
      rd_bin = fwp_pkg::fwp_gray2bin(wr_reg.rdg_s2);
      ptr = wr_reg.wr_bin;
      used = '0;
      free = '0;
      wr_next = wr_reg;
      // synchronisers: settings are static once enable arrives
      wr_next.cfg_s1 = port_cfg;
      wr_next.cfg_s2 = wr_reg.cfg_s1;
      wr_next.rdg_s1 = rd_gray;
      wr_next.rdg_s2 = wr_reg.rdg_s1;
      // enable and select both low, sampled at the rising edge only
      accept_rise = cfg.enable && !wen_n && !write_select_n;
      // owed falling word goes first, it precedes this rising word
      if (wr_reg.pend_fall && ((ptr - rd_bin) != fwp_pkg::FULL_CNT))
      begin
         wr_next.mem[ptr[fwp_pkg::ADDR_W-1:0]] = fall_data_reg;
         ptr = ptr + fwp_pkg::PTR_ONE;
      end
      // rising word, dropped when the fifo has no room
      if (accept_rise && ((ptr - rd_bin) != fwp_pkg::FULL_CNT))
      begin
         wr_next.mem[ptr[fwp_pkg::ADDR_W-1:0]] = wdata;
         ptr = ptr + fwp_pkg::PTR_ONE;
      end
      // a falling word is owed only after an accepted rising word,
      // so a burst can never open on a falling edge
      wr_next.pend_fall = accept_rise && cfg.ddr;
      wr_next.wr_bin = ptr;
      // a double rate edge may store two words; the published pointer
      // steps by one per edge so its gray code flips a single bit,
      // at the cost of the read side seeing such words a little later
      if (wr_reg.pub_bin != ptr)
      begin
         wr_next.pub_bin = wr_reg.pub_bin + fwp_pkg::PTR_ONE;
      end
      wr_next.wr_gray = fwp_pkg::fwp_bin2gray(wr_next.pub_bin);
      // flags use the possibly stale read pointer: pessimistic, never unsafe
      used = ptr - rd_bin;
      free = fwp_pkg::FULL_CNT - used;
      if (!cfg.enable)
      begin
         // unused port keeps both flags inactive high
         wr_next.flag_fr = 1'b1;
         wr_next.flag_paf = 1'b1;
      end
      else
      begin
         // standard: low means full; fall-through: low means room
         wr_next.flag_fr = cfg.fallthrough ? (used == fwp_pkg::FULL_CNT)
                                           : (used != fwp_pkg::FULL_CNT);
         wr_next.flag_paf = !(free <= cfg.paf_offset);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge wclk or negedge nrst)
   begin
      if (!nrst)
      begin
         wr_reg <= WR_RESET;
      end
      else
      begin
         wr_reg <= wr_next;
      end
   end

   assign wr_gray = wr_reg.wr_gray;
   assign mem = wr_reg.mem;
   assign full_or_input_ready = wr_reg.flag_fr;
   assign almost_full_flag = wr_reg.flag_paf;

endmodule

// [verilog/fwp_top.sv]
`timescale 1ns/100ps
module fwp_top #(
   parameter int SETTLE_CYC = fwp_pkg::CFG_SETTLE_CYC
) (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic [fwp_pkg::NUM_FIFO-1:0] WCLK,
   input wire logic [fwp_pkg::NUM_FIFO-1:0] WEN_N,
   input wire logic [fwp_pkg::NUM_FIFO-1:0] WRITE_SELECT_N,
   input wire fwp_pkg::fwp_data_arr_t WDATA,
   input wire fwp_pkg::fwp_setup_t SETUP,
   input wire logic [fwp_pkg::NUM_FIFO-1:0] RD_REQ,
   output logic [fwp_pkg::NUM_FIFO-1:0] FULL_OR_INPUT_READY,
   output logic [fwp_pkg::NUM_FIFO-1:0] ALMOST_FULL_FLAG,
   output fwp_pkg::fwp_data_arr_t RD_DATA,
   output logic [fwp_pkg::NUM_FIFO-1:0] RD_VALID,
   output logic [fwp_pkg::NUM_FIFO-1:0] FIFO_EMPTY,
   output fwp_pkg::fwp_setup_t SETUP_LATCHED,
   output logic SETUP_DONE
);

   ////////////////////////////////////////////////////////////////////////////////
   // elaboration checks
   localparam logic [fwp_pkg::CNT_W-1:0] SETTLE_LAST = fwp_pkg::CNT_W'(SETTLE_CYC);

   generate
      if ((SETTLE_CYC < 2) || (SETTLE_CYC >= (1 << fwp_pkg::CNT_W)))
      begin : g_bad_settle
         $error("settle count must cover the pin synchroniser and fit its counter");
      end
      if (fwp_pkg::ADDR_W < 2)
      begin : g_bad_depth
         $error("fifo depth must be at least four words");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // state of the system clock domain
   typedef struct packed {
      fwp_pkg::fwp_cfg_state_t cfg_state; // set-up latch sequence
      logic [fwp_pkg::CNT_W-1:0] settle_cnt; // cycles since reset release
      fwp_pkg::fwp_setup_t setup_s1; // set-up pins, first sync stage
      fwp_pkg::fwp_setup_t setup_s2; // set-up pins, usable
      fwp_pkg::fwp_setup_t setup; // latched set-up
      logic done; // set-up latched, ports running
      fwp_pkg::fwp_port_cfg_t [fwp_pkg::NUM_FIFO-1:0] pcfg; // per-port settings
      fwp_pkg::fwp_ptr_arr_t wrg_s1; // write pointers, first sync stage
      fwp_pkg::fwp_ptr_arr_t wrg_s2; // write pointers, usable
      fwp_pkg::fwp_ptr_arr_t rd_bin; // read pointers
      fwp_pkg::fwp_ptr_arr_t rd_gray; // published read pointers
      fwp_pkg::fwp_data_arr_t rd_data; // drained words
      logic [fwp_pkg::NUM_FIFO-1:0] rd_valid; // drained word strobe
      logic [fwp_pkg::NUM_FIFO-1:0] empty; // fifo empty as seen here
   } fwp_top_state_t;

   localparam fwp_top_state_t TOP_RESET = '{cfg_state: fwp_pkg::CFG_WAIT, empty: '1, default: '0};

   fwp_top_state_t st_reg; // registered state
   fwp_top_state_t st_next; // next state

   // wires between the ports and this domain
   fwp_pkg::fwp_ptr_arr_t wr_gray_w; // write pointers from the ports
   fwp_pkg::fwp_mem_t [fwp_pkg::NUM_FIFO-1:0] mem_w; // storage of each port
   logic [fwp_pkg::NUM_FIFO-1:0] flag_fr_w; // full or input ready per port
   logic [fwp_pkg::NUM_FIFO-1:0] flag_paf_w; // almost full per port

   ////////////////////////////////////////////////////////////////////////////////
   // one write port per fifo, each on its own write clock
   generate
      for (genvar i = 0; i < fwp_pkg::NUM_FIFO; i++)
      begin : g_port
         fwp_port u_port (
            .wclk(WCLK[i]),
            .nrst(NRST),
            .port_cfg(st_reg.pcfg[i]),
            .wen_n(WEN_N[i]),
            .write_select_n(WRITE_SELECT_N[i]),
            .wdata(WDATA[i]),
            .rd_gray(st_reg.rd_gray[i]),
            .wr_gray(wr_gray_w[i]),
            .mem(mem_w[i]),
            .full_or_input_ready(flag_fr_w[i]),
            .almost_full_flag(flag_paf_w[i])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // set-up latch and drain logic
   always_comb
   begin
      logic [fwp_pkg::PTR_W-1:0] wr_bin;
      logic [fwp_pkg::PTR_W-1:0] rd_ptr;
      logic port_empty;
      wr_bin = '0;
      rd_ptr = '0;
      port_empty = 1'b1;
      st_next = st_reg;
      // set-up pins come from straps outside any clock: two flops first
      st_next.setup_s1 = SETUP;
      st_next.setup_s2 = st_reg.setup_s1;
      st_next.wrg_s1 = wr_gray_w;
      st_next.wrg_s2 = st_reg.wrg_s1;

      // latch sequence: pins are taken once, right after master reset;
      // changes later are ignored until the next reset
      case (st_reg.cfg_state)
         fwp_pkg::CFG_WAIT:
         begin
            // wait for the pin synchroniser to hold reset-time levels
            st_next.settle_cnt = st_reg.settle_cnt + fwp_pkg::CNT_ONE;
            if (st_reg.settle_cnt == SETTLE_LAST)
            begin
               st_next.cfg_state = fwp_pkg::CFG_LATCH;
            end
         end
         fwp_pkg::CFG_LATCH:
         begin
            // capture every set-up pin at once
            st_next.setup = st_reg.setup_s2;
            for (int i = 0; i < fwp_pkg::NUM_FIFO; i++)
            begin
               // fields settle a cycle ahead of enable, so the port sees
               // them stable when its enable arrives through its synchroniser
               st_next.pcfg[i].enable = 1'b0;
               st_next.pcfg[i].ddr = st_reg.setup_s2.write_rate_select;
               st_next.pcfg[i].fallthrough = st_reg.setup_s2.fallthrough_or_serial_in;
               st_next.pcfg[i].paf_offset =
                  fwp_pkg::fwp_default_offset(st_reg.setup_s2.default_offset_select);
            end
            st_next.cfg_state = fwp_pkg::CFG_RUN;
         end
         fwp_pkg::CFG_RUN:
         begin
            // quad: all ports; dual: odd ports stay off whatever their pins do
            for (int i = 0; i < fwp_pkg::NUM_FIFO; i++)
            begin
               st_next.pcfg[i].enable = st_reg.setup.quad_dual_select || (i % 2 == 0);
            end
            st_next.done = 1'b1;
         end
         default:
         begin
            // unreachable codes recover through a fresh latch
            st_next.cfg_state = fwp_pkg::CFG_WAIT;
            st_next.settle_cnt = '0;
         end
      endcase

      // drain side: one word per request, read pointer published as gray
      for (int i = 0; i < fwp_pkg::NUM_FIFO; i++)
      begin
         wr_bin = fwp_pkg::fwp_gray2bin(st_reg.wrg_s2[i]);
         rd_ptr = st_reg.rd_bin[i];
         port_empty = (rd_ptr == wr_bin);
         st_next.rd_valid[i] = 1'b0;
         if (RD_REQ[i] && !port_empty)
         begin
            // the word was written before its pointer was published
            st_next.rd_data[i] = mem_w[i][rd_ptr[fwp_pkg::ADDR_W-1:0]];
            st_next.rd_valid[i] = 1'b1;
            rd_ptr = rd_ptr + fwp_pkg::PTR_ONE;
         end
         st_next.rd_bin[i] = rd_ptr;
         st_next.rd_gray[i] = fwp_pkg::fwp_bin2gray(rd_ptr);
         st_next.empty[i] = (rd_ptr == wr_bin);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         st_reg <= TOP_RESET;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs; the write-side flags come from the port flops, in their own clocks
   assign FULL_OR_INPUT_READY = flag_fr_w;
   assign ALMOST_FULL_FLAG = flag_paf_w;
   assign RD_DATA = st_reg.rd_data;
   assign RD_VALID = st_reg.rd_valid;
   assign FIFO_EMPTY = st_reg.empty;
   assign SETUP_LATCHED = st_reg.setup;
   assign SETUP_DONE = st_reg.done;

endmodule
